// ### weq_top.sv
// Purpose: input event qualifier of a complementary waveform unit
// Assumes: axi4-lite slave, one clock, synchronous active-low reset
// Notes:   hands rising and falling events to the waveform core
//
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - enabled source in edge mode fires rising event on low-to-high after phase delay
// - enabled source in level mode fires rising event while high, no delay
// - rising enable zero ignores the source regardless of mode
// - rising mode bits map nco, third_pulse_width_out, second_capture_compare_out, first_capture_compare_out, cell1, cmp2, cmp1, pin
// - falling enable bit one enables source, zero blocks it
// - falling enable bits use same source positions as rising bits
// - enabled falling source in edge mode fires on high-to-low after phase delay
// - enabled falling source in level mode fires immediately while low
// - falling enable zero ignores the source regardless of mode
// - falling mode bits map like falling enables, bit 0 is pin
// - source 0 comes from the pin chosen by the pin route
// - rising enable bit one enables source, zero blocks it
// - rising event delays primary output by the rising dead-band count
module weq_top
  import weq_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  pins_in,
  input  wire logic        cmp1_out,
  input  wire logic        cmp2_out,
  input  wire logic        first_logic_cell_out,
  input  wire logic        first_capture_compare_out,
  input  wire logic        second_capture_compare_out,
  input  wire logic        third_pulse_width_out,
  input  wire logic        numeric_oscillator_out,
  input  wire logic        delay_chain_tick,
  output logic             rise_event,
  output logic             fall_event,
  output logic             primary_out
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] rise_en_r;
  logic [7:0] rise_mode_r;
  logic [7:0] fall_en_r;
  logic [7:0] fall_mode_r;
  logic [2:0] pin_route_r;
  logic [5:0] rise_db_r;
  logic       rise_dbs_r;

  // ---------------------------------------------------------------
  // write channel
  // ---------------------------------------------------------------
  logic        aw_held_r;
  logic        w_held_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;

  wire        aw_take   = s_axi_awvalid & s_axi_awready;
  wire        w_take    = s_axi_wvalid & s_axi_wready;
  wire        aw_have   = aw_held_r | aw_take;
  wire        w_have    = w_held_r | w_take;
  wire [7:0]  wr_addr   = aw_held_r ? aw_addr_r : s_axi_awaddr[7:0];
  wire [31:0] wr_data   = w_held_r ? w_data_r : s_axi_wdata;
  wire [3:0]  wr_strb   = w_held_r ? w_strb_r : s_axi_wstrb;
  wire        wr_fire   = aw_have & w_have & ~bvalid_r;
  wire        wr_lane0  = wr_fire & wr_strb[0];

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == WEQ_OFS_RISE_EN) | (a == WEQ_OFS_RISE_MODE) |
                 (a == WEQ_OFS_FALL_EN) | (a == WEQ_OFS_FALL_MODE) |
                 (a == WEQ_OFS_PIN_ROUTE) | (a == WEQ_OFS_RISE_DB) |
                 (a == WEQ_OFS_STATUS);
  endfunction : addr_known

  assign s_axi_awready = ~aw_held_r & ~bvalid_r;
  assign s_axi_wready  = ~w_held_r & ~bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= WEQ_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_addr_r <= s_axi_awaddr[7:0];
      end
      if (w_take) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= addr_known(wr_addr) ? WEQ_RESP_OKAY : WEQ_RESP_SLVERR;
      end else begin
        aw_held_r <= aw_have;
        w_held_r  <= w_have;
        if (s_axi_bready) begin
          bvalid_r <= 1'b0;
        end
      end
    end
  end

  // status is read-only; writes there are accepted and dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rise_en_r   <= WEQ_RST_SEL;
      rise_mode_r <= WEQ_RST_SEL;
      fall_en_r   <= WEQ_RST_SEL;
      fall_mode_r <= WEQ_RST_SEL;
      pin_route_r <= WEQ_RST_ROUTE;
      rise_db_r   <= WEQ_RST_DB;
      rise_dbs_r  <= 1'b0;
    end else if (wr_lane0) begin
      case (wr_addr)
        WEQ_OFS_RISE_EN:   rise_en_r   <= wr_data[7:0];
        WEQ_OFS_RISE_MODE: rise_mode_r <= wr_data[7:0];
        WEQ_OFS_FALL_EN:   fall_en_r   <= wr_data[7:0];
        WEQ_OFS_FALL_MODE: fall_mode_r <= wr_data[7:0];
        WEQ_OFS_PIN_ROUTE: pin_route_r <= wr_data[2:0];
        WEQ_OFS_RISE_DB: begin
          rise_db_r  <= wr_data[WEQ_DB_W-1:0];
          rise_dbs_r <= wr_data[WEQ_DBS_BIT];
        end
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic [7:0]  rd_byte;
  logic        db_busy_r;

  wire       ar_take = s_axi_arvalid & s_axi_arready;
  wire [7:0] ra      = s_axi_araddr[7:0];
  wire [7:0] status  = {4'h0, db_busy_r, primary_out, fall_event, rise_event};

  assign rd_byte = (ra == WEQ_OFS_RISE_EN)   ? rise_en_r :
                   (ra == WEQ_OFS_RISE_MODE) ? rise_mode_r :
                   (ra == WEQ_OFS_FALL_EN)   ? fall_en_r :
                   (ra == WEQ_OFS_FALL_MODE) ? fall_mode_r :
                   (ra == WEQ_OFS_PIN_ROUTE) ? {5'h00, pin_route_r} :
                   (ra == WEQ_OFS_RISE_DB)   ? {rise_dbs_r, 1'b0, rise_db_r} :
                   (ra == WEQ_OFS_STATUS)    ? status : 8'h00;

  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= WEQ_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r  <= {24'h00_0000, rd_byte};
      rresp_r  <= addr_known(ra) ? WEQ_RESP_OKAY : WEQ_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // source gathering and qualification
  // ---------------------------------------------------------------
  logic [7:0] src;
  wire        routed_pin = pins_in[pin_route_r];
  weq_sel_s   rise_sel;
  weq_sel_s   fall_sel;

  assign rise_sel = '{en: rise_en_r, mode: rise_mode_r};
  assign fall_sel = '{en: fall_en_r, mode: fall_mode_r};

  assign src = {numeric_oscillator_out, third_pulse_width_out,
                second_capture_compare_out, first_capture_compare_out,
                first_logic_cell_out, cmp2_out, cmp1_out, routed_pin};

  weq_qual u_rise (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .src         (src),
    .sel         (rise_sel),
    .active_high (1'b1),
    .event_out   (rise_event)
  );

  weq_qual u_fall (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .src         (src),
    .sel         (fall_sel),
    .active_high (1'b0),
    .event_out   (fall_event)
  );

  // ---------------------------------------------------------------
  // rising dead-band delay of the primary output
  // ---------------------------------------------------------------
  logic [5:0] db_cnt_r;
  logic       prim_r;
  logic       rise_seen_r;

  // count ticks of aclk or of the delay chain; chain ticks come in synchronous
  wire db_tick  = rise_dbs_r ? delay_chain_tick : 1'b1;
  wire rise_new = rise_event & ~rise_seen_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      db_cnt_r    <= 6'h00;
      db_busy_r   <= 1'b0;
      prim_r      <= 1'b0;
      rise_seen_r <= 1'b0;
    end else begin
      rise_seen_r <= rise_event;
      if (fall_event) begin
        // falling dead-band lives outside this block; drop at once
        prim_r    <= 1'b0;
        db_busy_r <= 1'b0;
      end else if (rise_new && !prim_r && !db_busy_r) begin
        db_cnt_r  <= rise_db_r;
        db_busy_r <= (rise_db_r != 6'h00);
        prim_r    <= (rise_db_r == 6'h00);
      end else if (db_busy_r && db_tick) begin
        if (db_cnt_r <= 6'h01) begin
          db_busy_r <= 1'b0;
          prim_r    <= 1'b1;
        end
        db_cnt_r <= db_cnt_r - 6'h01;
      end
    end
  end

  assign primary_out = prim_r;

endmodule : weq_top
`default_nettype wire

// ### weq_pkg.sv
// Purpose: shared constants and types for the waveform event input qualifier
// Assumes: 32-bit axi4-lite register bus, 100 MHz clock
// Notes:   registers take one aligned word each, data in the low byte
package weq_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] WEQ_OFS_RISE_EN   = 8'h00;
  localparam logic [7:0] WEQ_OFS_RISE_MODE = 8'h04;
  localparam logic [7:0] WEQ_OFS_FALL_EN   = 8'h08;
  localparam logic [7:0] WEQ_OFS_FALL_MODE = 8'h0C;
  localparam logic [7:0] WEQ_OFS_PIN_ROUTE = 8'h10;
  localparam logic [7:0] WEQ_OFS_RISE_DB   = 8'h14;
  localparam logic [7:0] WEQ_OFS_STATUS    = 8'h18;

  localparam logic [7:0] WEQ_RST_SEL       = 8'h00;
  localparam logic [5:0] WEQ_RST_DB        = 6'h00;
  localparam logic [2:0] WEQ_RST_ROUTE     = 3'h0;

  // ---------------------------------------------------------------
  // source bit positions
  // ---------------------------------------------------------------
  localparam int WEQ_SRC_PIN   = 0;
  localparam int WEQ_SRC_CMP1  = 1;
  localparam int WEQ_SRC_CMP2  = 2;
  localparam int WEQ_SRC_CELL1 = 3;
  localparam int WEQ_SRC_FIRST_CAPTURE_COMPARE_OUT  = 4;
  localparam int WEQ_SRC_SECOND_CAPTURE_COMPARE_OUT  = 5;
  localparam int WEQ_SRC_THIRD_PULSE_WIDTH_OUT  = 6;
  localparam int WEQ_SRC_NCO   = 7;
  localparam int WEQ_NSRC      = 8;
  localparam int WEQ_NPIN      = 8;
  localparam int WEQ_DB_W      = 6;
  localparam int WEQ_DBS_BIT   = 7;

  localparam logic [1:0] WEQ_RESP_OKAY   = 2'h0;
  localparam logic [1:0] WEQ_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] en;
    logic [7:0] mode;
  } weq_sel_s;

  typedef struct packed {
    logic rise;
    logic fall;
  } weq_evt_s;

endpackage : weq_pkg

// ### weq_qual.sv
// Purpose: qualifies eight sources for one event direction
// Assumes: sources are synchronous to aclk
// Notes:   edge path waits one phase-delay cycle, level path is immediate
`timescale 1ns/1ps
`default_nettype none
module weq_qual
  import weq_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [7:0] src,
  input  wire weq_sel_s   sel,
  input  wire logic       active_high,
  output logic            event_out
);
  logic [7:0] prev_r;
  logic [7:0] asserted;
  logic [7:0] edge_hit;
  logic [7:0] level_hit;
  logic       edge_r;
  logic       edge_nxt;

  // polarity folds rising and falling into one shape
  assign asserted  = active_high ? src : ~src;
  assign edge_hit  = sel.en & sel.mode & asserted & ~(active_high ? prev_r : ~prev_r);
  assign level_hit = sel.en & ~sel.mode & asserted;
  assign edge_nxt  = |edge_hit;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_r <= active_high ? 8'hFF : 8'h00;
      edge_r <= 1'b0;
    end else begin
      prev_r <= src;
      edge_r <= edge_nxt;
    end
  end

  // phase delay: edge events leave one cycle later, level events at once
  assign event_out = edge_r | (|level_hit);

endmodule : weq_qual
`default_nettype wire

// ### weq_assertions.sv
// Purpose: port-level checks for the waveform event input qualifier
// Assumes: bound into weq_top, one clock, sync active-low reset
// Notes:   register state is hidden here, so checks lean on bus and outputs
`timescale 1ns/1ps
`default_nettype none
module weq_assertions
  import weq_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        rise_event,
  input wire logic        fall_event,
  input wire logic        primary_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // --------------------------------
  // bus answers and events
  // --------------------------------
  AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid) else $error("write answer late");
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  AST_UPPER_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_ERR_DATA: assert property (s_axi_rvalid && s_axi_rresp == WEQ_RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
  AST_RST_QUIET: assert property ($rose(aresetn) |-> !rise_event && !fall_event && !primary_out)
    else $error("events after reset");
  AST_FALL_CLEARS: assert property (fall_event && !rise_event |=> !primary_out)
    else $error("primary kept after fall");
  cover property (rise_event);
  cover property (fall_event);
  cover property ($rose(primary_out));
endmodule : weq_assertions
bind weq_top weq_assertions u_chk (.*);
`default_nettype wire

// ### weq_src_model.sv
// Purpose: stand-in for the comparators, timers, logic cell and input pins
// Assumes: src_cmd changes right after a clock edge
// Notes:   purely combinational, sources are plain levels
`timescale 1ns/1ps
`default_nettype none
module weq_src_model
(
  input  wire logic [7:0] src_cmd,
  input  wire logic [2:0] route,
  output logic      [7:0] pins_in,
  output logic            cmp1_out,
  output logic            cmp2_out,
  output logic            first_logic_cell_out,
  output logic            first_capture_compare_out,
  output logic            second_capture_compare_out,
  output logic            third_pulse_width_out,
  output logic            numeric_oscillator_out
);
  // unrouted pins carry the opposite level so a wrong route shows
  assign pins_in = {8{~src_cmd[0]}} ^ (8'h01 << route);
  assign {numeric_oscillator_out, third_pulse_width_out, second_capture_compare_out,
          first_capture_compare_out, first_logic_cell_out, cmp2_out, cmp1_out} = src_cmd[7:1];
endmodule : weq_src_model
`default_nettype wire

// ### weq_tb.sv
// Purpose: self-checking bench for the waveform event input qualifier
// Assumes: sources follow src_cmd through the partner model
// Notes:   chain ticks pulsed by hand; one mid-run reset checks the clear
`timescale 1ns/1ps
`default_nettype none
module testbench
  import weq_pkg::*;
;
  logic        aclk = 1'b0, aresetn = 1'b0, delay_chain_tick = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        rise_event, fall_event, primary_out, cmp1_out, cmp2_out, first_logic_cell_out;
  logic        first_capture_compare_out, second_capture_compare_out;
  logic        third_pulse_width_out, numeric_oscillator_out;
  logic [7:0]  pins_in, src_cmd = 8'h00;
  logic [2:0]  route = 3'h0;
  int          err_total = 0;
  int          check_count = 0;

  weq_top       u_dut (.*);
  weq_src_model u_src (.*);

  always #5 aclk = ~aclk;
  // --------------------------------
  // bus and compare tasks
  // --------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %0t got %0h exp %0h", $time, g, e);
    end
  endtask : chk

  task automatic chk_ev(input logic [1:0] e);
    check_count++;
    if ({rise_event, fall_event} !== e) begin
      err_total++;
      $display("ERROR %0t got %0h exp %0h", $time, {rise_event, fall_event}, e);
    end
  endtask : chk_ev

  // requests stand until their ready is seen high at a rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    // ready one cycle late so the answer has to stand
    @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic wok(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk({30'h0, r}, {30'h0, WEQ_RESP_OKAY});
  endtask : wok

  task automatic ev(input logic [7:0] v, input int n, input logic [1:0] e);
    src_cmd <= v;
    repeat (n) @(posedge aclk);
    #1 chk_ev(e);
    @(posedge aclk);
  endtask : ev

  task automatic end_sim();
    if (err_total == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  // --------------------------------
  // tests
  // --------------------------------
  initial begin
    #200000;
    err_total++;
    end_sim();
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  b;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int k = 0; k < 4; k++) begin
      rd(WEQ_OFS_RISE_EN + 8'(4 * k), d, r);
      chk(d, 32'h0);
      wok(WEQ_OFS_RISE_EN + 8'(4 * k), 32'hFFFF_FFA5);
      rd(WEQ_OFS_RISE_EN + 8'(4 * k), d, r);
      chk(d, 32'h0000_00A5);
    end
    rd(8'h40, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, WEQ_RESP_SLVERR});
    wr(8'h40, 32'h1, r);
    chk({30'h0, r}, {30'h0, WEQ_RESP_SLVERR});
    for (int m = 0; m < 2; m++) begin
      wok(WEQ_OFS_RISE_MODE, m ? 32'hFF : 32'h0);
      wok(WEQ_OFS_FALL_MODE, m ? 32'hFF : 32'h0);
      for (int i = 0; i < 8; i++) begin
        b = 8'h01 << i;
        src_cmd <= 8'h00;
        wok(WEQ_OFS_RISE_EN, {24'h0, b});
        wok(WEQ_OFS_FALL_EN, {24'h0, b});
        if (m == 0) begin
          ev(b, 0, 2'b10);
          ev(~b, 0, 2'b01);
        end else begin
          ev(~b, 1, 2'b00);
          ev(b, 1, 2'b10);
          ev(b, 0, 2'b00);
          ev(8'h00, 1, 2'b01);
          ev(8'h00, 0, 2'b00);
        end
      end
    end
    wok(WEQ_OFS_RISE_MODE, 32'h0);
    wok(WEQ_OFS_FALL_EN, 32'h0);
    wok(WEQ_OFS_RISE_EN, 32'h81);
    ev(8'h80, 0, 2'b10);
    ev(8'h01, 0, 2'b10);
    ev(8'h7E, 0, 2'b00);
    wok(WEQ_OFS_RISE_EN, 32'h01);
    for (int k = 0; k < 8; k++) begin
      route <= 3'(k);
      wok(WEQ_OFS_PIN_ROUTE, 32'(k));
      ev(8'h01, 0, 2'b10);
      ev(8'h00, 0, 2'b00);
    end
    wok(WEQ_OFS_FALL_EN, 32'h01);
    wok(WEQ_OFS_FALL_MODE, 32'h0);
    wok(WEQ_OFS_RISE_DB, 32'h03);
    src_cmd <= 8'h01;
    repeat (3) @(posedge aclk);
    #1 chk({31'h0, primary_out}, 32'h0);
    @(posedge aclk);
    #1 chk({31'h0, primary_out}, 32'h1);
    @(posedge aclk);
    src_cmd <= 8'h00;
    @(posedge aclk);
    #1 chk({31'h0, primary_out}, 32'h0);
    @(posedge aclk);
    wok(WEQ_OFS_RISE_DB, 32'h82);
    rd(WEQ_OFS_RISE_DB, d, r);
    chk(d, 32'h0000_0082);
    src_cmd <= 8'h01;
    repeat (3) @(posedge aclk);
    delay_chain_tick <= 1'b1;
    #1 chk({31'h0, primary_out}, 32'h0);
    @(posedge aclk);
    #1 chk({31'h0, primary_out}, 32'h0);
    @(posedge aclk);
    delay_chain_tick <= 1'b0;
    #1 chk({31'h0, primary_out}, 32'h1);
    @(posedge aclk);
    rd(WEQ_OFS_STATUS, d, r);
    chk(d, 32'h0000_0005);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1 chk_ev(2'b00);
    chk({31'h0, primary_out}, 32'h0);
    @(posedge aclk);
    for (int k = 0; k < 4; k++) begin
      rd(WEQ_OFS_RISE_EN + 8'(4 * k), d, r);
      chk(d, 32'h0);
    end
    end_sim();
  end
endmodule : testbench
`default_nettype wire
